// file: design/adcc_pkg.sv
// package: register map, field layouts and codes of the converter control
package adcc_pkg;

   // -----------------------------------------------------------------
   // register offsets (byte addresses on the 8-bit register port)
   // -----------------------------------------------------------------
   localparam logic [3:0] ADDR_SC1      = 4'h0;
   localparam logic [3:0] ADDR_SC2      = 4'h1;
   localparam logic [3:0] ADDR_RES_HIGH = 4'h2;
   localparam logic [3:0] ADDR_RES_LOW  = 4'h3;
   localparam logic [3:0] ADDR_CV_HIGH  = 4'h4;
   localparam logic [3:0] ADDR_CV_LOW   = 4'h5;
   localparam logic [3:0] ADDR_CFG      = 4'h6;
   localparam logic [3:0] ADDR_PCTL1    = 4'h7;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_SC1   = 8'h1F;
   localparam logic [7:0] RST_SC2   = 8'h00;
   localparam logic [7:0] RST_CFG   = 8'h00;
   localparam logic [7:0] RST_BYTE  = 8'h00;

   // -----------------------------------------------------------------
   // codes
   // -----------------------------------------------------------------
   localparam logic [4:0] CHAN_OFF     = 5'h1F;
   localparam logic [1:0] MODE_8BIT    = 2'h0;
   localparam logic [1:0] MODE_12BIT   = 2'h1;
   localparam logic [1:0] MODE_10BIT   = 2'h2;
   localparam logic [1:0] ICLK_BUS     = 2'h0;
   localparam logic [1:0] ICLK_BUS_DIV2 = 2'h1;
   localparam logic [1:0] ICLK_ALT     = 2'h2;
   localparam logic [1:0] ICLK_ASYNC   = 2'h3;

   // interrupt status bit positions
   localparam int IRQ_BIT_DONE    = 0;
   localparam int IRQ_BIT_DISCARD = 1;

   // first status/control register layout
   typedef struct packed {
      logic       conv_complete_flag;
      logic       conv_irq_enable;
      logic       continuous_enable;
      logic [4:0] channel_select;
   } adcc_sc1_t;

   // second status/control register layout
   typedef struct packed {
      logic       busy;
      logic       hw_trig_sel;
      logic       cmp_enable;
      logic       cmp_greater;
      logic [3:0] spare;
   } adcc_sc2_t;

   // configuration register layout
   typedef struct packed {
      logic       low_power;
      logic [1:0] clock_divide_sel;
      logic       long_sample;
      logic [1:0] mode;
      logic [1:0] input_clock_sel;
   } adcc_cfg_t;

   // converter state
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } adcc_state_t;

endpackage

// file: design/adcc_top.sv
// module: conversion control of a 12-bit successive-approximation converter
//
// Functional notes
// [RL1] conversion clock is selected input clock divided by 1, 2, 4 or 8
// [RL2] configuration bits 3:2 pick 8, 12 or 10 bit result, 11 reserved
// [RL3] configuration bits 1:0 pick bus, bus/2, alternate or async clock
// [RL4] software trigger: write of channel not all ones starts a conversion
// [RL5] hardware trigger: each trigger input event starts a conversion; here only events while idle start one
// [RL6] continuous mode restarts as soon as a result is transferred
// [RL7] continuous sequence starts on write or trigger, runs until abort
// [RL8] completion means result moved to result bytes, flag set then
// [RL9] interrupt raised when enable bit high as completion flag sets; here irq also needs irq_mask_ff bit 0 set, which resets to 0
// [RL10] 10/12 bit: high read but low unread blocks and discards result
// [RL11] single conversion, compare on and false: ignore blocking, stop
// [RL12] any other blocked transfer starts another conversion
// [RL13] software must not read results before a single conversion ends
// [RL14] first control write aborts; restarts only if channel not all ones
// [RL15] writes to control two, configuration or compare values abort
// [RL16] abort on reset and on stop entry without async clock selected
// [RL17] pin control bits take port control away from analog pins
// [RL18] reading low result byte ends the read in progress
// [RL19] all-ones channel write leaves the converter idle
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module adcc_top
   import adcc_pkg::*;
#(
   parameter int RES_W = 12
)
(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // register port
   input  wire logic [3:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [7:0]       reg_rdata,
   // clock sources, sampled
   input  wire logic             alternate_clock,
   input  wire logic             async_conv_clock,
   // system
   input  wire logic             hw_trigger,
   input  wire logic             stop_mode,
   // analog converter core
   output logic                  conv_start,
   output logic                  conv_abort,
   output logic      [4:0]       conv_channel,
   output logic                  conversion_clock,
   input  wire logic             core_done,
   input  wire logic [RES_W-1:0] core_result,
   // pins and interrupt
   output logic      [7:0]       pin_control_one,
   output logic                  irq
);

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   adcc_sc1_t       sc1_ff;
   adcc_sc2_t       sc2_ff;
   adcc_cfg_t       cfg_ff;
   logic [7:0]      cv_high_ff;
   logic [7:0]      cv_low_ff;
   logic [7:0]      res_high_ff;
   logic [7:0]      res_low_ff;
   logic [7:0]      pctl1_ff;
   logic [1:0]      irq_stat_ff;
   logic [1:0]      irq_mask_ff;
   logic [7:0]      rdata_ff;
   logic            read_busy_ff;
   adcc_state_t     state_ff;
   logic            start_ff;
   logic            abort_ff;
   logic            half_ff;
   logic            alt_prev_ff;
   logic            async_prev_ff;
   logic            trig_prev_ff;
   logic            stop_prev_ff;
   logic [2:0]      div_cnt_ff;
   logic            conv_clk_ff;

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   logic            wr_sc1;
   logic            wr_mode;
   logic            rd_high;
   logic            rd_low;
   logic            rd_stat;
   logic            trig_evt;
   logic            stop_abort;
   logic            sw_go;
   logic            hw_go;
   logic            done_evt;
   logic            cmp_true;
   logic            blocked;
   logic            transfer;
   logic            restart;
   logic [11:0]     res_full;
   logic [11:0]     res_masked;
   logic [11:0]     cmp_val;
   logic            src_tick;
   logic [2:0]      div_lim;
   logic [1:0]      irq_set;

   // register writes and reads of interest
   assign wr_sc1  = reg_wr && (reg_addr == ADDR_SC1);
   assign wr_mode = reg_wr && ((reg_addr == ADDR_SC2) ||
                               (reg_addr == ADDR_CFG) ||
                               (reg_addr == ADDR_CV_HIGH) ||
                               (reg_addr == ADDR_CV_LOW));
   assign rd_high = reg_rd && (reg_addr == ADDR_RES_HIGH);
   assign rd_low  = reg_rd && (reg_addr == ADDR_RES_LOW);
   assign rd_stat = reg_rd && (reg_addr == ADDR_IRQ_STAT);

   // trigger rising edge and stop entry
   assign trig_evt   = hw_trigger && !trig_prev_ff;
   assign stop_abort = stop_mode && !stop_prev_ff &&
                       (cfg_ff.input_clock_sel != ICLK_ASYNC); // RL16

   // start requests
   assign sw_go = wr_sc1 && !sc2_ff.hw_trig_sel &&
                  (reg_wdata[4:0] != CHAN_OFF); // RL4 RL14 RL19
   assign hw_go = sc2_ff.hw_trig_sel && trig_evt &&
                  (state_ff == ST_IDLE) &&
                  (sc1_ff.channel_select != CHAN_OFF); // RL5

   // result width per mode, right justified
   always_comb
   begin
      res_full = '0;
      res_full[RES_W-1:0] = core_result;
      case (cfg_ff.mode) // RL2
         MODE_8BIT:  res_masked = {4'h0, res_full[7:0]};
         MODE_10BIT: res_masked = {2'h0, res_full[9:0]};
         default:    res_masked = res_full;
      endcase
   end
   // compare against the software value
   assign cmp_val  = {cv_high_ff[3:0], cv_low_ff};
   assign cmp_true = !sc2_ff.cmp_enable ||
                     (sc2_ff.cmp_greater ? (res_masked >= cmp_val)
                                         : (res_masked <  cmp_val));
   // completion outcome
   assign done_evt = core_done && (state_ff == ST_CONV) &&
                     !wr_sc1 && !wr_mode && !stop_abort;
   assign blocked  = read_busy_ff &&
                     (cfg_ff.mode != MODE_8BIT); // RL10
   assign transfer = done_evt && cmp_true && !blocked; // RL8
   always_comb
   begin
      restart = 1'b0;
      if (done_evt)
      begin
         if (!sc1_ff.continuous_enable && sc2_ff.cmp_enable && !cmp_true)
            restart = 1'b0; // RL11
         else if (blocked)
            restart = 1'b1; // RL12
         else
            restart = sc1_ff.continuous_enable; // RL6 RL7
      end
   end

   // ---------------------------
   // conversion clock generation
   // ---------------------------
   // source tick per input clock selection
   always_comb
   begin
      case (cfg_ff.input_clock_sel) // RL3
         ICLK_BUS:      src_tick = 1'b1;
         ICLK_BUS_DIV2: src_tick = half_ff;
         ICLK_ALT:      src_tick = alternate_clock && !alt_prev_ff;
         default:       src_tick = async_conv_clock && !async_prev_ff;
      endcase
   end
   // divider limit of 0, 1, 3 or 7 source ticks
   assign div_lim = 3'((4'h1 << cfg_ff.clock_divide_sel) - 4'h1); // RL1
   // edge history of sampled inputs
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         half_ff       <= 1'b0;
         alt_prev_ff   <= 1'b0;
         async_prev_ff <= 1'b0;
         trig_prev_ff  <= 1'b0;
         stop_prev_ff  <= 1'b0;
      end
      else
      begin
         half_ff       <= !half_ff;
         alt_prev_ff   <= alternate_clock;
         async_prev_ff <= async_conv_clock;
         trig_prev_ff  <= hw_trigger;
         stop_prev_ff  <= stop_mode;
      end
   end
   // divider, one-cycle conversion clock tick
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_cnt_ff  <= 3'h0;
         conv_clk_ff <= 1'b0;
      end
      else if (wr_mode)
      begin
         div_cnt_ff  <= 3'h0; // restart divider on mode change
         conv_clk_ff <= 1'b0;
      end
      else if (src_tick && (div_cnt_ff >= div_lim))
      begin
         div_cnt_ff  <= 3'h0; // RL1
         conv_clk_ff <= 1'b1;
      end
      else
      begin
         div_cnt_ff  <= src_tick ? div_cnt_ff + 3'h1 : div_cnt_ff;
         conv_clk_ff <= 1'b0;
      end
   end

   // ---------------------
   // conversion sequencing
   // ---------------------
   // state, start and abort pulses to the core
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_IDLE; // RL16
         start_ff <= 1'b0;
         abort_ff <= 1'b0;
      end
      else
      begin
         start_ff <= 1'b0;
         abort_ff <= 1'b0;
         if (wr_sc1 || wr_mode || stop_abort)
         begin
            abort_ff <= (state_ff == ST_CONV); // RL14 RL15 RL16
            state_ff <= sw_go ? ST_CONV : ST_IDLE; // RL19
            start_ff <= sw_go; // RL4
         end
         else if (hw_go)
         begin
            state_ff <= ST_CONV; // RL5 RL7
            start_ff <= 1'b1;
         end
         else if (done_evt)
         begin
            state_ff <= restart ? ST_CONV : ST_IDLE;
            start_ff <= restart; // RL6 RL12
         end
      end
   end

   // -----------------
   // control registers
   // -----------------
   // first status/control: fields and completion flag
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         sc1_ff <= adcc_sc1_t'(RST_SC1);
      else
      begin
         if (wr_sc1)
         begin
            sc1_ff.conv_irq_enable   <= reg_wdata[6];
            sc1_ff.continuous_enable <= reg_wdata[5];
            sc1_ff.channel_select    <= reg_wdata[4:0];
         end
         // set wins over write or low-byte read clear
         if (transfer)
            sc1_ff.conv_complete_flag <= 1'b1; // RL8
         else if (wr_sc1 || rd_low)
            sc1_ff.conv_complete_flag <= 1'b0;
      end
   end
   // mode registers
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sc2_ff     <= adcc_sc2_t'(RST_SC2);
         cfg_ff     <= adcc_cfg_t'(RST_CFG);
         cv_high_ff <= RST_BYTE;
         cv_low_ff  <= RST_BYTE;
         pctl1_ff   <= RST_BYTE;
      end
      else if (reg_wr)
      begin
         if (reg_addr == ADDR_SC2)
            sc2_ff[6:4] <= reg_wdata[6:4];
         else if (reg_addr == ADDR_CFG)
            cfg_ff <= adcc_cfg_t'(reg_wdata);
         else if (reg_addr == ADDR_CV_HIGH)
            cv_high_ff <= {4'h0, reg_wdata[3:0]};
         else if (reg_addr == ADDR_CV_LOW)
            cv_low_ff <= reg_wdata;
         else if (reg_addr == ADDR_PCTL1)
            pctl1_ff <= reg_wdata; // RL17
      end
   end
   // result bytes and read-in-progress tracking
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         res_high_ff  <= RST_BYTE;
         res_low_ff   <= RST_BYTE;
         read_busy_ff <= 1'b0;
      end
      else
      begin
         if (transfer)
         begin
            res_high_ff <= {4'h0, res_masked[11:8]};
            res_low_ff  <= res_masked[7:0];
         end
         if (rd_low)
            read_busy_ff <= 1'b0; // RL18
         else if (rd_high)
            read_busy_ff <= 1'b1; // RL10
      end
   end

   // ----------
   // interrupts
   // ----------
   // done event gated by enable at flag set, discard event always
   always_comb
   begin
      irq_set = 2'h0;
      irq_set[IRQ_BIT_DONE]    = transfer && sc1_ff.conv_irq_enable; // RL9
      irq_set[IRQ_BIT_DISCARD] = done_evt && blocked && cmp_true;
   end
   // sticky status, read clears, set wins
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_stat_ff <= 2'h0;
         irq_mask_ff <= 2'h0;
      end
      else
      begin
         irq_stat_ff <= (rd_stat ? 2'h0 : irq_stat_ff) | irq_set;
         if (reg_wr && (reg_addr == ADDR_IRQ_MASK))
            irq_mask_ff <= reg_wdata[1:0];
      end
   end

   // -------------------------------------
   // read data, one cycle after the strobe
   // -------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_ff <= RST_BYTE;
      else if (reg_rd)
      begin
         if (reg_addr == ADDR_SC1)
            rdata_ff <= sc1_ff;
         else if (reg_addr == ADDR_SC2)
            rdata_ff <= {(state_ff == ST_CONV), sc2_ff[6:4], 4'h0};
         else if (reg_addr == ADDR_RES_HIGH)
            rdata_ff <= res_high_ff;
         else if (reg_addr == ADDR_RES_LOW)
            rdata_ff <= res_low_ff;
         else if (reg_addr == ADDR_CV_HIGH)
            rdata_ff <= cv_high_ff;
         else if (reg_addr == ADDR_CV_LOW)
            rdata_ff <= cv_low_ff;
         else if (reg_addr == ADDR_CFG)
            rdata_ff <= cfg_ff;
         else if (reg_addr == ADDR_PCTL1)
            rdata_ff <= pctl1_ff;
         else if (reg_addr == ADDR_IRQ_STAT)
            rdata_ff <= {6'h00, irq_stat_ff};
         else if (reg_addr == ADDR_IRQ_MASK)
            rdata_ff <= {6'h00, irq_mask_ff};
         else
            rdata_ff <= RST_BYTE; // unmapped reads zero
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign reg_rdata        = rdata_ff;
   assign conv_start       = start_ff;
   assign conv_abort       = abort_ff;
   assign conv_channel     = sc1_ff.channel_select;
   assign conversion_clock = conv_clk_ff;
   assign pin_control_one  = pctl1_ff; // RL17
   assign irq              = |(irq_stat_ff & irq_mask_ff);

endmodule // adcc_top

// file: tb/adc_conversion_control_test.sv
// testbench: register-level tests of the converter control
`timescale 1ns/1ps
module adc_conversion_control_test
   import adcc_pkg::*;
;
   logic        core_clk, rst_n, reg_wr, reg_rd, irq;
   logic        alternate_clock, async_conv_clock, hw_trigger, stop_mode;
   logic        conv_start, conv_abort, conversion_clock, core_done;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, pin_control_one, latency;
   logic [4:0]  conv_channel;
   logic [11:0] core_result, sample;
   logic [2:0]  src_ff;
   int          mismatches = 0, samples_checked = 0, starts = 0, aborts = 0;
   int          ticks = 0, s0, a0, t0, d;
   logic [3:0]  ab_a [4] = '{ADDR_SC2, ADDR_CV_HIGH, ADDR_CV_LOW, ADDR_CFG};
   logic [7:0]  ab_d [4] = '{8'h00, 8'h0F, 8'hFF, 8'h04};

   adcc_top dut_u (.*);
   adcc_core_model core_u (.*);

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // source clocks of period 4 and 8; event counters
   always @(posedge core_clk)
   begin
      src_ff           <= src_ff + 3'h1;
      alternate_clock  <= src_ff[1];
      async_conv_clock <= src_ff[2];
      starts += (conv_start === 1'b1);
      aborts += (conv_abort === 1'b1);
      ticks  += (conversion_clock === 1'b1);
   end

   task automatic check(input string n, input logic [11:0] s, e);
      samples_checked++;
      if (s !== e)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      repeat (2) @(negedge core_clk);
   endtask

   task automatic rchk(input logic [3:0] a, input logic [7:0] e, string n);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      check(n, 12'(reg_rdata), 12'(e));
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (core_done !== 1'b1 && n < 300)
      begin
         @(negedge core_clk);
         n++;
      end
      check("done wait", 12'(n < 300), 12'h1);
      repeat (3) @(negedge core_clk);
   endtask

   task automatic start(input logic [7:0] v, input logic [11:0] r);
      sample = r;
      s0     = starts;
      wr(ADDR_SC1, v);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      conclude();
   end

   initial
   begin
      {rst_n, reg_wr, reg_rd, hw_trigger, stop_mode} = 5'h00;
      {reg_addr, reg_wdata, src_ff} = 15'h0000;
      latency = 8'h0A;
      sample  = 12'h000;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      // ----------
      // reset values, pins, one plain conversion
      // ----------
      rchk(ADDR_SC1, RST_SC1, "sc1");
      rchk(ADDR_SC2, RST_SC2, "sc2");
      rchk(ADDR_CFG, RST_CFG, "cfg");
      rchk(4'hF, 8'h00, "unmapped");
      wr(ADDR_PCTL1, 8'hA5);
      check("pins", 12'(pin_control_one), 12'h0A5);
      wr(ADDR_IRQ_MASK, 8'h01);
      wr(ADDR_CFG, 8'h04);
      start(8'h45, 12'hABC);
      check("start", 12'(starts), 12'(s0 + 1));
      wait_done();
      check("irq", 12'(irq), 12'h1);
      rchk(ADDR_SC1, 8'hC5, "flag");
      rchk(ADDR_RES_HIGH, 8'h0A, "high");
      rchk(ADDR_RES_LOW, 8'hBC, "low");
      rchk(ADDR_IRQ_STAT, 8'h01, "stat");
      rchk(ADDR_IRQ_STAT, 8'h00, "stat clear");
      // ----------
      // blocking, discard and restart; compare false stops
      // ----------
      latency = 8'h1E;
      rchk(ADDR_RES_HIGH, 8'h0A, "high again");
      start(8'h45, 12'h123);
      wait_done();
      sample = 12'h456;
      rchk(ADDR_IRQ_STAT, 8'h02, "discard");
      rchk(ADDR_RES_LOW, 8'hBC, "low kept");
      wait_done();
      check("restart", 12'(starts), 12'(s0 + 2));
      rchk(ADDR_RES_HIGH, 8'h04, "high new");
      wr(ADDR_CV_HIGH, 8'h0F);
      wr(ADDR_CV_LOW, 8'hFF);
      wr(ADDR_SC2, 8'h30);
      start(8'h45, 12'h123);
      wait_done();
      check("cmp stop", 12'(starts), 12'(s0 + 1));
      rchk(ADDR_SC2, 8'h30, "idle");
      wr(ADDR_SC2, 8'h00);
      rchk(ADDR_RES_LOW, 8'h56, "low new");
      wr(ADDR_CFG, 8'h00);
      rchk(ADDR_RES_HIGH, 8'h04, "high 8bit");
      start(8'h45, 12'h07E);
      wait_done();
      rchk(ADDR_SC1, 8'hC5, "no block");
      rchk(ADDR_RES_LOW, 8'h7E, "low 8bit");
      wr(ADDR_CFG, 8'h04);
      // ----------
      // continuous, aborts, interrupt mask, hardware trigger
      // ----------
      latency = 8'h04;
      start(8'h65, 12'h321);
      repeat (60) @(negedge core_clk);
      check("cont", 12'(starts >= s0 + 5), 12'h1);
      a0 = aborts;
      start(8'h1F, 12'h321);
      repeat (20) @(negedge core_clk);
      check("abort", 12'(aborts), 12'(a0 + 1));
      check("stay idle", 12'(starts), 12'(s0));
      check("irq set", 12'(irq), 12'h1);
      wr(ADDR_IRQ_MASK, 8'h00);
      check("irq masked", 12'(irq), 12'h0);
      rchk(ADDR_IRQ_STAT, 8'h01, "stat cont");
      wr(ADDR_IRQ_MASK, 8'h01);
      check("irq clear", 12'(irq), 12'h0);
      latency = 8'h32;
      for (int i = 0; i < 6; i++)
      begin
         if (i > 3)
            wr(ADDR_CFG, (i == 4) ? 8'h04 : 8'h07);
         start(8'h05, 12'h000);
         a0 = aborts;
         if (i < 4)
            wr(ab_a[i], ab_d[i]);
         else
         begin
            stop_mode <= 1'b1;
            repeat (5) @(posedge core_clk);
            stop_mode <= 1'b0;
         end
         check("mode abort", 12'(aborts - a0), 12'(i != 5));
         wr(ADDR_SC1, 8'h1F);
      end
      latency = 8'h0A;
      wr(ADDR_SC2, 8'h40);
      start(8'h05, 12'h9F0);
      check("no sw start", 12'(starts), 12'(s0));
      hw_trigger <= 1'b1;
      repeat (3) @(posedge core_clk);
      hw_trigger <= 1'b0;
      wait_done();
      check("hw start", 12'(starts), 12'(s0 + 1));
      rchk(ADDR_RES_HIGH, 8'h09, "hw high");
      rchk(ADDR_RES_LOW, 8'hF0, "hw low");
      wr(ADDR_SC2, 8'h00);
      // ----------
      // conversion clock for each source and divider
      // ----------
      for (int s = 0; s < 4; s++)
         for (int v = 0; v < 4; v++)
         begin
            wr(ADDR_CFG, {1'b0, 2'(v), 3'b001, 2'(s)});
            repeat (16) @(negedge core_clk);
            t0 = ticks;
            repeat (192) @(negedge core_clk);
            d = ticks - t0 - 192 / ((1 << s) << v);
            check("clk ticks", 12'(d >= -1 && d <= 1), 12'h1);
         end
      conclude();
   end
endmodule // adc_conversion_control_test

// file: tb/adcc_core_model.sv
// model: analog converter core answering start and abort
`timescale 1ns/1ps
module adcc_core_model
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // control from the block
   input  wire logic        conv_start,
   input  wire logic        conv_abort,
   // test settings
   input  wire logic [7:0]  latency,
   input  wire logic [11:0] sample,
   // answer
   output logic             core_done,
   output logic [11:0]      core_result
);
   logic [7:0] left_ff;
   logic       run_ff;

   // count a conversion down; a start wins over an abort
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run_ff  <= 1'b0;
         left_ff <= 8'h00;
      end
      else if (conv_start)
      begin
         run_ff  <= 1'b1;
         left_ff <= latency;
      end
      else if (conv_abort || left_ff == 8'h00)
         run_ff <= 1'b0;
      else
         left_ff <= left_ff - 8'h01;
   end

   assign core_done   = run_ff && left_ff == 8'h00;
   // result is garbage away from the done pulse
   assign core_result = core_done ? sample : ~sample;
endmodule // adcc_core_model

// file: tb/adcc_top_sva.sv
// checker: port-level assertions of the converter control
`timescale 1ns/1ps
module adcc_top_sva
   import adcc_pkg::*;
(
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rst_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   // system and core
   input wire logic       hw_trigger,
   input wire logic       stop_mode,
   input wire logic       conv_start,
   input wire logic       conv_abort,
   input wire logic [4:0] conv_channel,
   input wire logic       conversion_clock,
   input wire logic       core_done,
   // pins and interrupt
   input wire logic [7:0] pin_control_one,
   input wire logic       irq
);
   logic       hw_sel_ff;
   logic [1:0] div_ff;
   logic [1:0] iclk_ff;
   logic [3:0] quiet_ff;
   logic       sc1_wr_ff;
   logic       abort_wr_ff;
   logic [3:0] trig_ff;
   logic [3:0] stop_ff;
   logic [3:0] done_ff;
   logic       w_sc1;

   assign w_sc1 = reg_wr && reg_addr == ADDR_SC1;

   // mirror of trigger select and clock settings
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hw_sel_ff <= 1'b0;
         div_ff    <= 2'h0;
         iclk_ff   <= 2'h0;
         quiet_ff  <= 4'h0;
      end
      else
      begin
         if (reg_wr && reg_addr == ADDR_SC2)
            hw_sel_ff <= reg_wdata[6];
         if (reg_wr && reg_addr == ADDR_CFG)
         begin
            div_ff   <= reg_wdata[6:5];
            iclk_ff  <= reg_wdata[1:0];
            quiet_ff <= 4'h0;
         end
         else if (quiet_ff != 4'hF)
            quiet_ff <= quiet_ff + 4'h1; // cycles since a clock change
      end
   end

   // short history of the causes of starts and aborts
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sc1_wr_ff   <= 1'b0;
         abort_wr_ff <= 1'b0;
         trig_ff     <= 4'h0;
         stop_ff     <= 4'h0;
         done_ff     <= 4'h0;
      end
      else
      begin
         sc1_wr_ff   <= w_sc1;
         abort_wr_ff <= reg_wr && (reg_addr inside {ADDR_SC1, ADDR_SC2,
                        ADDR_CV_HIGH, ADDR_CV_LOW, ADDR_CFG});
         trig_ff     <= {trig_ff[2:0], hw_trigger};
         stop_ff     <= {stop_ff[2:0], stop_mode};
         done_ff     <= {done_ff[2:0], core_done};
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_sw_start:
      assert property (w_sc1 && reg_wdata[4:0] != CHAN_OFF && !hw_sel_ff
         |=> conv_start) else $error("no start after channel write");
   chk_off_idle:
      assert property (w_sc1 && reg_wdata[4:0] == CHAN_OFF |=> !conv_start)
         else $error("start after all-ones channel write");
   chk_start_cause:
      assert property (conv_start |-> sc1_wr_ff || |done_ff
         || |(trig_ff[2:0] & ~trig_ff[3:1]))
         else $error("start without a cause");
   chk_abort_cause:
      assert property (conv_abort |-> abort_wr_ff
         || |(stop_ff[2:0] & ~stop_ff[3:1]))
         else $error("abort without a cause");
   chk_channel_reg:
      assert property (w_sc1 |=> conv_channel == $past(reg_wdata[4:0]))
         else $error("channel not taken from write");
   chk_pin_ctrl:
      assert property (reg_wr && reg_addr == ADDR_PCTL1
         |=> pin_control_one == $past(reg_wdata))
         else $error("pin control not updated");
   chk_irq_mask:
      assert property (reg_wr && reg_addr == ADDR_IRQ_MASK
         && reg_wdata == 8'h00 |=> !irq) else $error("irq while masked");
   chk_div_eight:
      assert property (conversion_clock && quiet_ff == 4'hF && div_ff == 2'h3
         && iclk_ff == ICLK_BUS |=> !conversion_clock [*7])
         else $error("conversion clock tick too early");

   cov_start: cover property (conv_start);
   cov_abort: cover property (conv_abort);
   cov_irq:   cover property ($rose(irq));
endmodule // adcc_top_sva

bind adcc_top adcc_top_sva chk_u (.*);
